// ===== rtl/ies_pkg.sv
package ies_pkg;
  localparam int IES_NSRC = 8;
  localparam int IES_IDXW = 3;
  localparam logic [15:0] IES_SP_RST = 16'h00ff;
  localparam logic [15:0] IES_VEC_BASE = 16'h0000;
  localparam logic [15:0] IES_VEC_STEP = 16'h0002;
  localparam logic [7:0] IES_FLAG_SRC = 8'h3f;
  localparam logic [15:0] IES_PC_RST = 16'h0000;
  localparam int IES_ENTRY_CYC = 4;
  localparam int IES_JUMP_CYC = 3;
  localparam int IES_WAKE_CYC = 4;
  localparam int IES_RET_CYC = 4;
  localparam logic [1:0] IES_ENTRY_LAST = 2'(IES_ENTRY_CYC - 1);
  localparam logic [1:0] IES_JUMP_LAST = 2'(IES_JUMP_CYC - 1);
  localparam logic [1:0] IES_WAKE_LAST = 2'(IES_WAKE_CYC - 1);
  localparam logic [1:0] IES_RET_LAST = 2'(IES_RET_CYC - 1);
  typedef enum logic [2:0] {
    IES_IDLE,
    IES_SLEEP_WAIT,
    IES_WAKE_EXTRA,
    IES_ENTRY,
    IES_JUMP,
    IES_RET
  } ies_state_t;
endpackage

// ===== rtl/ies_pick_if.sv
`timescale 1ns/1ns
interface ies_pick_if;
  import ies_pkg::*;
  logic [IES_NSRC-1:0] req;
  logic valid;
  logic [IES_IDXW-1:0] idx;
  modport arb (input req, output valid, output idx);
  modport seq (output req, input valid, input idx);
endinterface

// ===== rtl/ies_prio_pick.sv
`timescale 1ns/1ns
module ies_prio_pick
  import ies_pkg::*;
(
  ies_pick_if.arb pick
);
  // Lowest source index sits at the lowest vector and wins.
  logic [IES_IDXW-1:0] idx_chain [IES_NSRC:0];
  assign idx_chain[IES_NSRC] = '0;
  genvar g;
  generate
    for (g = 0; g < IES_NSRC; g++) begin : g_pri
      assign idx_chain[g] = pick.req[g] ? IES_IDXW'(g) : idx_chain[g+1];
    end
  endgenerate
  assign pick.idx = idx_chain[0];
  assign pick.valid = |pick.req;
endmodule

// ===== rtl/ies_seq.sv
`timescale 1ns/1ns
// What this block does
// - Entry takes at least four cycles
// - Push program counter before vector fetch
// - Vector jump takes three cycles
// - Finish multi-cycle instruction before entry
// - Wake from sleep adds four cycles
// - Return takes four cycles total
// - Return pops two bytes, stack pointer plus two
// - Return sets global interrupt enable
// - Entry clears global interrupt enable
// - Vectoring clears source pending flag for sources 0 to 5 only (IES_FLAG_SRC)
// - One instruction runs after return first
// - Lowest vector served first
module ies_seq
  import ies_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [IES_NSRC-1:0] IRQ_PEND,
  input wire logic INSTR_DONE,
  input wire logic SLEEPING,
  input wire logic WAKE_READY,
  input wire logic RET_START,
  input wire logic GIE_SET,
  input wire logic GIE_CLR,
  input wire logic [15:0] PC_IN,
  input wire logic [15:0] JMP_TARGET,
  input wire logic [7:0] STK_RDATA,
  output logic [IES_NSRC-1:0] IRQ_ACK,
  output logic GIE,
  output logic STALL,
  output logic PC_LOAD,
  output logic [15:0] PC_NEW,
  output logic STK_WE,
  output logic STK_RE,
  output logic [15:0] STK_ADDR,
  output logic [7:0] STK_WDATA,
  output logic [15:0] SP
);

  ////////////////////////////////////////////////////////////////////////////
  // Source selection.
  ies_pick_if pick ();
  ies_prio_pick u_pick (
    .pick(pick)
  );
  assign pick.req = IRQ_PEND;

  ies_state_t state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [15:0] pc_save_r, pc_save_nxt;
  logic [IES_IDXW-1:0] idx_r, idx_nxt;
  logic [7:0] hi_r, hi_nxt;
  logic hold_one_r, hold_one_nxt;
  logic gie_r, gie_nxt;
  logic [15:0] sp_r, sp_nxt;
  logic stall_nxt, pc_load_nxt, we_nxt, re_nxt;
  logic [15:0] pc_new_nxt, addr_nxt;
  logic [7:0] wdata_nxt;
  logic [IES_NSRC-1:0] ack_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance and vector decode.
  wire logic boundary = INSTR_DONE | SLEEPING;
  wire logic accept = (state_r == IES_IDLE) && gie_r && pick.valid && boundary && !hold_one_r;
  wire logic start_ret = (state_r == IES_IDLE) && RET_START && !accept;
  wire logic cnt_end = (state_r == IES_ENTRY && cnt_r == IES_ENTRY_LAST) ||
                       (state_r == IES_JUMP && cnt_r == IES_JUMP_LAST) ||
                       (state_r == IES_WAKE_EXTRA && cnt_r == IES_WAKE_LAST) ||
                       (state_r == IES_RET && cnt_r == IES_RET_LAST);
  wire logic [15:0] vec_addr = 16'(IES_VEC_BASE + IES_VEC_STEP * (16'(idx_r) + 16'h0001));

  ////////////////////////////////////////////////////////////////////////////
  // Next-state and output decode.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_end ? 2'h0 : 2'(cnt_r + 2'h1);
    pc_save_nxt = pc_save_r;
    idx_nxt = idx_r;
    hi_nxt = hi_r;
    hold_one_nxt = hold_one_r && !INSTR_DONE;
    gie_nxt = (gie_r || GIE_SET) && !GIE_CLR;
    sp_nxt = sp_r;
    stall_nxt = 1'b1;
    pc_load_nxt = 1'b0;
    pc_new_nxt = PC_NEW;
    we_nxt = 1'b0;
    re_nxt = 1'b0;
    addr_nxt = STK_ADDR;
    wdata_nxt = STK_WDATA;
    ack_nxt = '0;
    if (GIE_SET) begin
      hold_one_nxt = 1'b1;
    end
    case (state_r)
      IES_IDLE: begin
        stall_nxt = 1'b0;
        cnt_nxt = 2'h0;
        if (accept) begin
          pc_save_nxt = PC_IN;
          idx_nxt = pick.idx;
          gie_nxt = 1'b0;
          ack_nxt = IES_FLAG_SRC & (IES_NSRC'(1) << pick.idx);
          stall_nxt = 1'b1;
          state_nxt = SLEEPING ? IES_SLEEP_WAIT : IES_ENTRY;
        end else if (start_ret) begin
          stall_nxt = 1'b1;
          state_nxt = IES_RET;
        end
      end
      IES_SLEEP_WAIT: begin
        cnt_nxt = 2'h0;
        if (WAKE_READY) begin
          state_nxt = IES_WAKE_EXTRA;
        end
      end
      IES_WAKE_EXTRA: begin
        if (cnt_end) begin
          state_nxt = IES_ENTRY;
        end
      end
      IES_ENTRY: begin
        case (cnt_r)
          2'h0: begin
            we_nxt = 1'b1;
            addr_nxt = sp_r;
            wdata_nxt = pc_save_r[7:0];
          end
          2'h1: begin
            we_nxt = 1'b1;
            addr_nxt = 16'(sp_r - 16'h0001);
            wdata_nxt = pc_save_r[15:8];
          end
          2'h2: begin
            sp_nxt = 16'(sp_r - 16'h0002);
          end
          default: begin
            pc_load_nxt = 1'b1;
            pc_new_nxt = vec_addr;
            state_nxt = IES_JUMP;
          end
        endcase
      end
      IES_JUMP: begin
        if (cnt_end) begin
          pc_load_nxt = 1'b1;
          pc_new_nxt = JMP_TARGET;
          state_nxt = IES_IDLE;
        end
      end
      IES_RET: begin
        case (cnt_r)
          2'h0: begin
            re_nxt = 1'b1;
            addr_nxt = 16'(sp_r + 16'h0001);
          end
          2'h1: begin
            re_nxt = 1'b1;
            addr_nxt = 16'(sp_r + 16'h0002);
          end
          2'h2: begin
            hi_nxt = STK_RDATA;
          end
          default: begin
            sp_nxt = 16'(sp_r + 16'h0002);
            gie_nxt = 1'b1;
            hold_one_nxt = 1'b1;
            pc_load_nxt = 1'b1;
            pc_new_nxt = {hi_r, STK_RDATA};
            state_nxt = IES_IDLE;
          end
        endcase
      end
      default: begin
        state_nxt = IES_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_r <= IES_IDLE;
      cnt_r <= 2'h0;
      pc_save_r <= IES_PC_RST;
      idx_r <= '0;
      hi_r <= 8'h00;
      hold_one_r <= 1'b0;
      gie_r <= 1'b0;
      sp_r <= IES_SP_RST;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pc_save_r <= pc_save_nxt;
      idx_r <= idx_nxt;
      hi_r <= hi_nxt;
      hold_one_r <= hold_one_nxt;
      gie_r <= gie_nxt;
      sp_r <= sp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      IRQ_ACK <= '0;
      GIE <= 1'b0;
      STALL <= 1'b0;
      PC_LOAD <= 1'b0;
      PC_NEW <= IES_PC_RST;
      STK_WE <= 1'b0;
      STK_RE <= 1'b0;
      STK_ADDR <= IES_SP_RST;
      STK_WDATA <= 8'h00;
      SP <= IES_SP_RST;
    end else begin
      IRQ_ACK <= ack_nxt;
      GIE <= gie_nxt;
      STALL <= stall_nxt;
      PC_LOAD <= pc_load_nxt;
      PC_NEW <= pc_new_nxt;
      STK_WE <= we_nxt;
      STK_RE <= re_nxt;
      STK_ADDR <= addr_nxt;
      STK_WDATA <= wdata_nxt;
      SP <= sp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence entry_push_s;
    ##2 STK_WE ##1 STK_WE ##1 !STK_WE ##1 PC_LOAD;
  endsequence

  sequence ret_pop_s;
    ##2 STK_RE ##1 STK_RE ##1 !STK_RE ##1 (PC_LOAD && GIE);
  endsequence

  entry_timing_a: assert property (accept && !SLEEPING |-> entry_push_s)
    else $error("Entry did not reach the vector four cycles after accept.");
  push_before_vec_a: assert property (accept && !SLEEPING |-> ##2 (STK_WE && STK_WDATA == $past(PC_IN, 2)[7:0]))
    else $error("Low program counter byte not pushed first.");
  jump_three_a: assert property (state_r == IES_ENTRY && cnt_r == IES_ENTRY_LAST |-> ##1 PC_LOAD ##1 !PC_LOAD ##1 !PC_LOAD ##1 PC_LOAD)
    else $error("Vector jump did not take three cycles.");
  boundary_only_a: assert property (state_r == IES_IDLE && $past(state_r) == IES_IDLE && !boundary |=> state_r == IES_IDLE || state_r == IES_RET)
    else $error("Entry started inside an instruction.");
  wake_extra_a: assert property (state_r == IES_SLEEP_WAIT && WAKE_READY |-> ##1 (state_r == IES_WAKE_EXTRA)[*4] ##1 state_r == IES_ENTRY)
    else $error("Wake-up did not add four cycles.");
  ret_timing_a: assert property (start_ret |-> ret_pop_s)
    else $error("Return did not finish in four cycles.");
  ret_sp_a: assert property (start_ret |-> ##5 SP == 16'($past(SP, 5) + 16'h0002))
    else $error("Return did not raise the stack pointer by two.");
  gie_clear_a: assert property (accept |=> !GIE && !gie_r)
    else $error("Global enable not cleared on entry.");
  flag_clear_a: assert property (accept |=> IRQ_ACK == (IES_FLAG_SRC & (IES_NSRC'(1) << $past(pick.idx))))
    else $error("Pending flag of the served source not cleared.");
  one_more_a: assert property (state_r == IES_RET && cnt_r == IES_RET_LAST |=> !accept)
    else $error("Interrupt taken right after return.");
  entry_sp_a: assert property (accept && !SLEEPING |-> ##4 SP == 16'($past(SP, 4) - 16'h0002))
    else $error("Entry did not lower the stack pointer by two.");
endmodule

// ===== testbench/ies_stack_model.sv
`timescale 1ns/1ns
// Stack memory beside the sequencer; read data is valid only in the cycle after a read strobe.
module ies_stack_model (
  input wire logic MCLK,
  input wire logic STK_WE,
  input wire logic STK_RE,
  input wire logic [15:0] STK_ADDR,
  input wire logic [7:0] STK_WDATA,
  output logic [7:0] STK_RDATA
);
  logic [7:0] mem [0:255];
  initial begin
    STK_RDATA = 8'ha5;
  end
  // Outside a read the data lines are scrambled every cycle.
  always @(posedge MCLK) begin
    if (STK_WE) begin
      mem[STK_ADDR[7:0]] <= STK_WDATA;
    end
    STK_RDATA <= STK_RE ? mem[STK_ADDR[7:0]] : ~STK_RDATA;
  end
endmodule

// ===== testbench/tb_interrupt_entry_return_sequencer.sv
`timescale 1ns/1ns
module tb_interrupt_entry_return_sequencer;
  import ies_pkg::*;
  typedef struct {logic [15:0] v; int cyc;} ies_exp_t;
  logic mclk = 1'b0, rst = 1'b1, done = 1'b1, slp = 1'b0, wake = 1'b0, ret_go = 1'b0, gset = 1'b0, gclr = 1'b0;
  logic [7:0] pend = 8'h00, ack, rdata, wdata;
  logic [15:0] pc_in = 16'h0000, jt = 16'h0000, pc_new, stk_addr, sp;
  logic gie, stall, pcl, we, re;
  int cyc = 0, n_fail = 0, checks = 0;
  logic [31:0] rs = 32'h89c71d97;
  ies_exp_t pq[$], aq[$], e;

  ies_seq ies_seq_i (.MCLK(mclk), .RST(rst), .IRQ_PEND(pend), .INSTR_DONE(done), .SLEEPING(slp),
    .WAKE_READY(wake), .RET_START(ret_go), .GIE_SET(gset), .GIE_CLR(gclr), .PC_IN(pc_in),
    .JMP_TARGET(jt), .STK_RDATA(rdata), .IRQ_ACK(ack), .GIE(gie), .STALL(stall), .PC_LOAD(pcl),
    .PC_NEW(pc_new), .STK_WE(we), .STK_RE(re), .STK_ADDR(stk_addr), .STK_WDATA(wdata), .SP(sp));
  ies_stack_model ies_stack_model_i (.MCLK(mclk), .STK_WE(we), .STK_RE(re), .STK_ADDR(stk_addr),
    .STK_WDATA(wdata), .STK_RDATA(rdata));

  initial begin
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task wait_idle;
    int k;
    repeat (2) @(negedge mclk);
    for (k = 0; k < 40 && stall !== 1'b0; k++) @(negedge mclk);
    if (stall !== 1'b0) begin
      n_fail++;
      finish_test();
    end
  endtask

  // One interrupt served and returned; mode 0 plain, 1 multi-cycle instruction, 2 from sleep.
  task run(input int i, input int mode);
    logic [7:0] p, av;
    logic [15:0] pcv;
    int a;
    rs = nxt(rs);
    p = (rs[7:0] | (8'h01 << i)) & ~((8'h01 << i) - 8'h01);
    pcv = rs[23:8];
    av = (8'h01 << i) & IES_FLAG_SRC;
    @(negedge mclk);
    pend <= p;
    pc_in <= pcv;
    jt <= rs[31:16];
    done <= (mode == 0);
    slp <= (mode == 2);
    if (av != 8'h00) aq.push_back('{{8'h00, av}, cyc + ((mode == 1) ? 4 : 1)});
    if (mode == 1) begin
      repeat (3) @(negedge mclk);
      done <= 1'b1;
    end
    a = cyc + 1;
    if (mode == 2) begin
      repeat (3) @(negedge mclk);
      wake <= 1'b1;
      a = cyc + 5;
    end
    pq.push_back('{16'(IES_VEC_BASE + IES_VEC_STEP * 16'(i + 1)), a + 4});
    pq.push_back('{rs[31:16], a + 7});
    @(negedge mclk);
    wake <= 1'b0;
    slp <= 1'b0;
    done <= 1'b1;
    wait_idle();
    check(ies_stack_model_i.mem[8'hff], pcv[7:0]);
    check(ies_stack_model_i.mem[8'hfe], pcv[15:8]);
    check(sp, IES_SP_RST - 16'h0002);
    check(gie, 1'b0);
    @(negedge mclk);
    pend <= 8'h00;
    ret_go <= 1'b1;
    pq.push_back('{pcv, cyc + 5});
    @(negedge mclk);
    ret_go <= 1'b0;
    wait_idle();
    check(sp, IES_SP_RST);
    check(gie, 1'b1);
    repeat (2) @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Every load and acknowledge is matched against the oldest note in its queue.
  always @(negedge mclk) begin
    if (pcl === 1'b1) begin
      e = pq.size() > 0 ? pq.pop_front() : ies_exp_t'{16'hxxxx, -1};
      check(pc_new, e.v);
      check(cyc, e.cyc);
    end
    if (ack !== 8'h00) begin
      e = aq.size() > 0 ? aq.pop_front() : ies_exp_t'{16'hxxxx, -1};
      check(ack, e.v[7:0]);
      check(cyc, e.cyc);
      check(gie, 1'b0);
    end
  end

  initial begin
    repeat (3) @(negedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    gclr <= 1'b1;
    pend <= 8'h01;
    @(negedge mclk);
    gclr <= 1'b0;
    repeat (5) @(negedge mclk);
    check(stall, 1'b0);
    pend <= 8'h00;
    gset <= 1'b1;
    @(negedge mclk);
    gset <= 1'b0;
    repeat (2) @(negedge mclk);
    for (int i = 0; i < 8; i++) begin
      run(i, i % 3);
    end
    check(pq.size() + aq.size(), 0);
    finish_test();
  end
endmodule
